/* File: logic/ppfm_pkg.sv */
// ppfm_pkg: register map, field positions and carrier types of the pin function mux
// assumes a 32-bit avalon-mm slave with byte addresses and 12 pins: port_a 0..7, port_b 8..11
package ppfm_pkg;
  localparam int          PPFM_AW         = 5;
  localparam int          PPFM_NPIN       = 12;
  localparam logic [4:0]  PPFM_OFF_CTRL   = 5'h00;
  localparam logic [4:0]  PPFM_OFF_DIDR   = 5'h04;
  localparam logic [4:0]  PPFM_OFF_PCIE   = 5'h08;
  localparam logic [4:0]  PPFM_OFF_AEN    = 5'h0c;
  localparam logic [4:0]  PPFM_OFF_PIN    = 5'h10;
  localparam logic [4:0]  PPFM_OFF_GOUT   = 5'h14;
  localparam logic [4:0]  PPFM_OFF_GDIR   = 5'h18;
  // control bits
  localparam int          PPFM_C_EXTCLK   = 0;
  localparam int          PPFM_C_REMAP    = 1;
  localparam int          PPFM_C_CLKOUT   = 2;
  localparam int          PPFM_C_USART    = 3;
  localparam int          PPFM_C_USCLK    = 4;
  localparam int          PPFM_C_CMPOUT   = 5;
  localparam int          PPFM_C_OCA      = 6;
  localparam int          PPFM_C_OCB      = 7;
  localparam int          PPFM_C_ACIN     = 8;
  localparam int          PPFM_CTRL_W     = 9;
  localparam logic [8:0]  PPFM_CTRL_RST   = 9'h000;
  localparam logic [11:0] PPFM_PIN_RST    = 12'h000;
  localparam logic [7:0]  PPFM_AEN_RST    = 8'h00;
  // pin indices
  localparam int          PPFM_PA0 = 0;
  localparam int          PPFM_PA1 = 1;
  localparam int          PPFM_PA2 = 2;
  localparam int          PPFM_PA3 = 3;
  localparam int          PPFM_PA4 = 4;
  localparam int          PPFM_PA5 = 5;
  localparam int          PPFM_PB0 = 8;
  localparam int          PPFM_PB1 = 9;
  localparam int          PPFM_PB2 = 10;
  localparam int          PPFM_PB3 = 11;

  typedef struct packed {
    logic [PPFM_AW-1:0] address;
    logic               read;
    logic               write;
    logic [31:0]        writedata;
  } ppfm_avm_req_t;

  typedef struct packed {
    logic sys_clock_out;
    logic compare_out_a;
    logic compare_out_b;
    logic usart_tx_pin;
    logic usart_clock_pin;
    logic comparator_out;
    logic prog_data_out;
    logic prog_data_oe;
  } ppfm_per_out_t;

  typedef struct packed {
    logic                 ext_clock_in;
    logic                 count_in;
    logic                 capture_in;
    logic                 usart_rx_pin;
    logic                 usart_clock_pin;
    logic                 ext_irq_line;
    logic                 prog_clock_pin;
    logic                 prog_data_pin;
    logic                 prog_reset_pin;
    logic [PPFM_NPIN-1:0] pin_change_irq;
    logic [7:0]           analog_connect;
    logic [1:0]           comparator_connect;
  } ppfm_per_in_t;
endpackage : ppfm_pkg

/* File: logic/ppfm_mux.sv */
// ppfm_mux: pin function multiplexer between port pins and on-chip peripherals
// assumes pins arrive unsynchronised; prog_mode and peripheral outputs are on clk
//
// Contract
// - after reset every pin is plain port logic and moves to a peripheral only when enabled.
// - with external_clock_select, port_a pin 0 feeds the clock, analog 0 is off and its buffer stays on.
// - a pin with both pin-change and analog enabled keeps its digital input buffer on.
// - while comparator_out drives port_b pin 3, its analog, count and receive inputs stay connected.
// - while compare_out_b drives a pin, enabled analog or comparator inputs there keep sampling.
// - on port_b pin 1 the clock output wins over compare_out_a.
// - during reset every pin is an input with its driver off; during external programming every pin but pa1, whose driver follows prog_data_oe.
// - with remap the timer uses pa3 for a, pa4 for capture, pa5 for b and pb3 for count.
// - programming uses pa0 clock, pa1 two-way data, pa2 reset; comparator inputs on pa0 and pa1.
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module ppfm_mux
  import ppfm_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire ppfm_pkg::ppfm_avm_req_t avm_req,
  output logic                         avm_waitrequest,
  output logic [31:0]                  avm_readdata,
  input  wire logic                    prog_mode,
  input  wire ppfm_pkg::ppfm_per_out_t per_out,
  output ppfm_pkg::ppfm_per_in_t       per_in,
  input  wire logic [11:0]             pin_in,
  output logic [11:0]                  pin_out,
  output logic [11:0]                  pin_oe,
  output logic [11:0]                  pin_buf_en
);
  import ppfm_pkg::*;

  typedef struct packed {
    logic [PPFM_CTRL_W-1:0] ctrl;
    logic [PPFM_NPIN-1:0]   didr;
    logic [PPFM_NPIN-1:0]   pcie;
    logic [7:0]             aen;
    logic [PPFM_NPIN-1:0]   gout;
    logic [PPFM_NPIN-1:0]   gdir;
    logic [PPFM_NPIN-1:0]   sync1;
    logic [PPFM_NPIN-1:0]   sync2;
    logic [PPFM_NPIN-1:0]   pout;
    logic [PPFM_NPIN-1:0]   poe;
    logic [PPFM_NPIN-1:0]   buf_en;
    ppfm_per_in_t           pin;
    logic                   ack;
    logic [31:0]            rdata;
  } ppfm_state_t;

  ppfm_state_t st;
  ppfm_state_t next_st;

  // pin index of each analog channel
  function automatic logic [3:0] ppfm_ch_pin(input int ch);
    case (ch)
      0:       ppfm_ch_pin = 4'(PPFM_PA0);
      1:       ppfm_ch_pin = 4'(PPFM_PA1);
      2:       ppfm_ch_pin = 4'(PPFM_PA5);
      3:       ppfm_ch_pin = 4'h6;
      4:       ppfm_ch_pin = 4'(PPFM_PB0);
      5:       ppfm_ch_pin = 4'(PPFM_PB1);
      6:       ppfm_ch_pin = 4'(PPFM_PB2);
      default: ppfm_ch_pin = 4'(PPFM_PB3);
    endcase
  endfunction : ppfm_ch_pin

  // read mux over the register map
  function automatic logic [31:0] ppfm_rd(input ppfm_state_t s, input logic [4:0] a);
    if (a == PPFM_OFF_CTRL) begin
      ppfm_rd = 32'(s.ctrl);
    end else if (a == PPFM_OFF_DIDR) begin
      ppfm_rd = 32'(s.didr);
    end else if (a == PPFM_OFF_PCIE) begin
      ppfm_rd = 32'(s.pcie);
    end else if (a == PPFM_OFF_AEN) begin
      ppfm_rd = 32'(s.aen);
    end else if (a == PPFM_OFF_PIN) begin
      ppfm_rd = 32'(s.sync2 & s.buf_en);
    end else if (a == PPFM_OFF_GOUT) begin
      ppfm_rd = 32'(s.gout);
    end else if (a == PPFM_OFF_GDIR) begin
      ppfm_rd = 32'(s.gdir);
    end else begin
      ppfm_rd = 32'h0000_0000;
    end
  endfunction : ppfm_rd

  logic                 req;
  logic                 take;
  logic                 remap;
  logic [PPFM_NPIN-1:0] an_on_pin;
  logic [PPFM_NPIN-1:0] din;

  assign req             = avm_req.read | avm_req.write;
  assign take            = req & st.ack;
  assign avm_waitrequest = req & ~st.ack;
  assign remap           = st.ctrl[PPFM_C_REMAP];

  always_comb begin
    next_st       = st;
    an_on_pin     = '0;
    din           = '0;
    // bus slave: one wait state, read data at the edge that raises ack, write effect at the next edge that ends the transfer
    next_st.ack   = req & ~st.ack;
    if (req & ~st.ack) begin
      next_st.rdata = ppfm_rd(st, avm_req.address);
    end
    if (take & avm_req.write) begin
      if (avm_req.address == PPFM_OFF_CTRL) begin
        next_st.ctrl = avm_req.writedata[PPFM_CTRL_W-1:0];
      end else if (avm_req.address == PPFM_OFF_DIDR) begin
        next_st.didr = avm_req.writedata[PPFM_NPIN-1:0];
      end else if (avm_req.address == PPFM_OFF_PCIE) begin
        next_st.pcie = avm_req.writedata[PPFM_NPIN-1:0];
      end else if (avm_req.address == PPFM_OFF_AEN) begin
        next_st.aen = avm_req.writedata[7:0];
      end else if (avm_req.address == PPFM_OFF_GOUT) begin
        next_st.gout = avm_req.writedata[PPFM_NPIN-1:0];
      end else if (avm_req.address == PPFM_OFF_GDIR) begin
        next_st.gdir = avm_req.writedata[PPFM_NPIN-1:0];
      end
    end
    // pin synchroniser
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;

    // analog channels connect independent of any output driver
    for (int c = 0; c < 8; c++) begin
      next_st.pin.analog_connect[c] = st.aen[c];
      an_on_pin[ppfm_ch_pin(c)]     = st.aen[c];
    end
    if (st.ctrl[PPFM_C_EXTCLK]) begin
      next_st.pin.analog_connect[0] = 1'b0;
    end
    next_st.pin.comparator_connect = {2{st.ctrl[PPFM_C_ACIN]}};

    // digital input buffers
    for (int i = 0; i < PPFM_NPIN; i++) begin
      next_st.buf_en[i] = ~st.didr[i] | (st.pcie[i] & an_on_pin[i]);
    end
    if (st.ctrl[PPFM_C_EXTCLK]) begin
      next_st.buf_en[PPFM_PA0] = 1'b1;
    end
    if (st.ctrl[PPFM_C_CMPOUT]) begin
      next_st.buf_en[PPFM_PB3] = 1'b1;
    end
    din = st.sync2 & st.buf_en;

    // peripheral inputs
    next_st.pin.ext_clock_in    = st.ctrl[PPFM_C_EXTCLK] & st.sync2[PPFM_PA0];
    next_st.pin.count_in        = remap ? din[PPFM_PB3] : din[PPFM_PA0];
    next_st.pin.capture_in      = remap ? din[PPFM_PA4] : din[PPFM_PB2];
    next_st.pin.usart_rx_pin    = din[PPFM_PB3];
    next_st.pin.usart_clock_pin = din[PPFM_PB1];
    next_st.pin.ext_irq_line    = din[PPFM_PB1];
    next_st.pin.pin_change_irq  = din & st.pcie;
    next_st.pin.prog_clock_pin  = prog_mode & st.sync2[PPFM_PA0];
    next_st.pin.prog_data_pin   = prog_mode & st.sync2[PPFM_PA1];
    next_st.pin.prog_reset_pin  = prog_mode & st.sync2[PPFM_PA2];

    // output drivers: port logic by default
    next_st.pout = st.gout;
    next_st.poe  = st.gdir;
    if (!remap && st.ctrl[PPFM_C_OCB]) begin
      next_st.pout[PPFM_PA1] = per_out.compare_out_b;
      next_st.poe[PPFM_PA1]  = 1'b1;
    end
    if (remap && st.ctrl[PPFM_C_OCA]) begin
      next_st.pout[PPFM_PA3] = per_out.compare_out_a;
      next_st.poe[PPFM_PA3]  = 1'b1;
    end
    if (remap && st.ctrl[PPFM_C_OCB]) begin
      next_st.pout[PPFM_PA5] = per_out.compare_out_b;
      next_st.poe[PPFM_PA5]  = 1'b1;
    end
    // pb1: clock out, then compare a, then usart clock
    if (st.ctrl[PPFM_C_CLKOUT]) begin
      next_st.pout[PPFM_PB1] = per_out.sys_clock_out;
      next_st.poe[PPFM_PB1]  = 1'b1;
    end else if (!remap && st.ctrl[PPFM_C_OCA]) begin
      next_st.pout[PPFM_PB1] = per_out.compare_out_a;
      next_st.poe[PPFM_PB1]  = 1'b1;
    end else if (st.ctrl[PPFM_C_USART] && st.ctrl[PPFM_C_USCLK]) begin
      next_st.pout[PPFM_PB1] = per_out.usart_clock_pin;
      next_st.poe[PPFM_PB1]  = 1'b1;
    end
    if (st.ctrl[PPFM_C_USART]) begin
      next_st.pout[PPFM_PB2] = per_out.usart_tx_pin;
      next_st.poe[PPFM_PB2]  = 1'b1;
    end
    if (st.ctrl[PPFM_C_CMPOUT]) begin
      next_st.pout[PPFM_PB3] = per_out.comparator_out;
      next_st.poe[PPFM_PB3]  = 1'b1;
    end
    // programming: all drivers off except the programmer's own data line
    if (prog_mode) begin
      next_st.pout          = '0;
      next_st.poe           = '0;
      next_st.pout[PPFM_PA1] = per_out.prog_data_out;
      next_st.poe[PPFM_PA1]  = per_out.prog_data_oe;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st.ctrl   <= PPFM_CTRL_RST;
      st.didr   <= PPFM_PIN_RST;
      st.pcie   <= PPFM_PIN_RST;
      st.aen    <= PPFM_AEN_RST;
      st.gout   <= PPFM_PIN_RST;
      st.gdir   <= PPFM_PIN_RST;
      st.sync1  <= PPFM_PIN_RST;
      st.sync2  <= PPFM_PIN_RST;
      st.pout   <= PPFM_PIN_RST;
      st.poe    <= PPFM_PIN_RST;
      st.buf_en <= 12'hfff;
      st.pin    <= '0;
      st.ack    <= 1'b0;
      st.rdata  <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  assign avm_readdata = st.rdata;
  assign per_in       = st.pin;
  assign pin_out      = st.pout;
  assign pin_oe       = st.poe;
  assign pin_buf_en   = st.buf_en;
endmodule : ppfm_mux
`default_nettype wire

/* File: bench/ppfm_chk.sv */
// ppfm_chk: port assertions for the pin function mux
// assumes bound to ppfm_mux; shadows control and direction writes itself
`timescale 1ns/1ps
`default_nettype none
module ppfm_chk
  import ppfm_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    rst,
  input wire ppfm_pkg::ppfm_avm_req_t avm_req,
  input wire logic                    avm_waitrequest,
  input wire logic                    prog_mode,
  input wire ppfm_pkg::ppfm_per_out_t per_out,
  input wire ppfm_pkg::ppfm_per_in_t  per_in,
  input wire logic [11:0]             pin_out,
  input wire logic [11:0]             pin_oe,
  input wire logic [11:0]             pin_buf_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [8:0]  c;
  logic [11:0] g;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c <= 9'h000;
      g <= 12'h000;
    end else if (avm_req.write && !avm_waitrequest) begin
      if (avm_req.address == PPFM_OFF_CTRL) c <= avm_req.writedata[8:0];
      if (avm_req.address == PPFM_OFF_GDIR) g <= avm_req.writedata[11:0];
    end
  end
  property p_plain; c == 9'h000 && !prog_mode |=> pin_oe == $past(g); endproperty
  a_plain: assert property (p_plain) else $error("port direction not on pins");
  property p_rst; disable iff (1'b0) rst |-> pin_oe == 12'h000; endproperty
  a_rst: assert property (p_rst) else $error("driver on in reset");
  property p_prog; prog_mode |=> (pin_oe & 12'hffd) == 12'h000; endproperty
  a_prog: assert property (p_prog) else $error("driver on in programming");
  property p_pdat; prog_mode |=> pin_oe[1] == $past(per_out.prog_data_oe); endproperty
  a_pdat: assert property (p_pdat) else $error("programming data enable lost");
  property p_sys_clock_out;
    c[PPFM_C_CLKOUT] && !prog_mode |=> pin_oe[9] && pin_out[9] == $past(per_out.sys_clock_out);
  endproperty
  a_sys_clock_out: assert property (p_sys_clock_out) else $error("clock out lost pb1");
  property p_oca;
    c[PPFM_C_OCA] && c[2:1] == 2'b00 && !prog_mode |=> pin_out[9] == $past(per_out.compare_out_a);
  endproperty
  a_oca: assert property (p_oca) else $error("compare a not on pb1");
  property p_ocar;
    c[PPFM_C_OCA] && c[PPFM_C_REMAP] && !prog_mode |=> pin_out[3] == $past(per_out.compare_out_a);
  endproperty
  a_ocar: assert property (p_ocar) else $error("compare a not on pa3");
  property p_ocb;
    c[PPFM_C_OCB] && !c[PPFM_C_REMAP] && !prog_mode |=> pin_out[1] == $past(per_out.compare_out_b);
  endproperty
  a_ocb: assert property (p_ocb) else $error("compare b not on pa1");
  property p_tx;
    c[PPFM_C_USART] && !prog_mode |=> pin_out[10] == $past(per_out.usart_tx_pin);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit not on pb2");
  property p_xclk; c[PPFM_C_EXTCLK] |=> pin_buf_en[0] && !per_in.analog_connect[0]; endproperty
  a_xclk: assert property (p_xclk) else $error("clock input pin misused");
  c_prog: cover property (prog_mode ##1 prog_mode);
  c_sys_clock_out: cover property (c[PPFM_C_CLKOUT] && c[PPFM_C_OCA]);
  c_remap: cover property (c[PPFM_C_REMAP] && c[PPFM_C_OCA]);
endmodule : ppfm_chk
bind ppfm_mux ppfm_chk ppfm_chk_i (.clk, .rst, .avm_req, .avm_waitrequest, .prog_mode,
  .per_out, .per_in, .pin_out, .pin_oe, .pin_buf_en);
`default_nettype wire

/* File: bench/ppfm_periph.sv */
// ppfm_periph: peripheral outputs and pad levels facing the mux
// assumes ext is the outside level of each released pin
`timescale 1ns/1ps
`default_nettype none
module ppfm_periph
  import ppfm_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic [11:0]             ext,
  input wire logic [11:0]             pin_out,
  input wire logic [11:0]             pin_oe,
  output var ppfm_pkg::ppfm_per_out_t per_out,
  output logic [11:0]                 pin_in
);
  logic [7:0] cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt <= 8'h00;
    else cnt <= cnt + 8'h01;
  end
  // each peripheral output toggles at its own rate; programmer data enable every cycle
  assign per_out = ppfm_per_out_t'(cnt);
  // driven pads follow the mux, released pads show the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : ppfm_periph
`default_nettype wire

/* File: bench/ppfm_mux_tb.sv */
// ppfm_mux_tb: register tasks and pin scenarios for the pin function mux
// assumes an avalon-mm slave with waitrequest; the master waits for the answer
`timescale 1ns/1ps
`default_nettype none
module ppfm_mux_tb;
  import ppfm_pkg::*;
  logic           clk, rst, prog_mode, avm_waitrequest;
  ppfm_avm_req_t  req;
  logic [31:0]    avm_readdata;
  logic [31:0]    rdata;
  ppfm_per_out_t  per_out;
  ppfm_per_in_t   per_in;
  logic [11:0]    pin_in, pin_out, pin_oe, pin_buf_en, ext;
  int             failures, n_compared;
  logic [8:0]     ck[7] = '{9'h044, 9'h040, 9'h042, 9'h080, 9'h082, 9'h008, 9'h018};
  logic [11:0]    oe[7] = '{12'h200, 12'h200, 12'h008, 12'h002, 12'h020, 12'h400, 12'h600};
  ppfm_mux ppfm_mux_i (.clk, .rst, .avm_req(req), .avm_waitrequest, .avm_readdata,
    .prog_mode, .per_out, .per_in, .pin_in, .pin_out, .pin_oe, .pin_buf_en);
  ppfm_periph ppfm_periph_i (.clk, .rst, .ext, .pin_out, .pin_oe, .per_out, .pin_in);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task finish_test;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, !w, w, d};
    do @(posedge clk); while (avm_waitrequest !== 1'b0);
    rdata = avm_readdata;
    req <= '{a, 1'b0, 1'b0, d};
  endtask : bus
  task rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rd
  task settle;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task cfg(input logic [8:0] c, input logic [11:0] d, p, input logic [7:0] a,
           input logic [11:0] e, input logic pm);
    @(posedge clk);
    ext <= e;
    prog_mode <= pm;
    bus(1'b1, PPFM_OFF_CTRL, 32'(c));
    bus(1'b1, PPFM_OFF_DIDR, 32'(d));
    bus(1'b1, PPFM_OFF_PCIE, 32'(p));
    bus(1'b1, PPFM_OFF_AEN, 32'(a));
    settle();
  endtask : cfg
  initial begin
    #50000;
    failures++;
    finish_test();
  end
  initial begin
    rst <= 1'b1;
    req = '0;
    prog_mode = 1'b0;
    ext = 12'h000;
    failures = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0);
    bus(1'b1, 5'h1c, 32'hffff);
    rd(5'h1c, 32'h0);
    bus(1'b1, PPFM_OFF_GOUT, 32'ha5a);
    bus(1'b1, PPFM_OFF_GDIR, 32'hfff);
    settle();
    chk(32'(pin_oe), 32'hfff);
    chk(32'(pin_out), 32'ha5a);
    rd(PPFM_OFF_PIN, 32'ha5a);
    cfg(9'h000, 12'h000, 12'h000, 8'h00, 12'h000, 1'b1);
    chk(32'(pin_oe & 12'hffd), 32'h0);
    bus(1'b1, PPFM_OFF_GDIR, 32'h0);
    cfg(9'h000, 12'hfff, 12'h002, 8'h02, 12'h000, 1'b0);
    chk(32'(pin_buf_en), 32'h002);
    cfg(9'h001, 12'hfff, 12'h002, 8'h03, 12'h001, 1'b0);
    chk(32'(pin_buf_en), 32'h003);
    chk(32'({per_in.analog_connect, 7'h0, per_in.ext_clock_in}), 32'h201);
    cfg(9'h120, 12'hfff, 12'h000, 8'h80, 12'h800, 1'b0);
    chk(32'({pin_buf_en, pin_oe}), 32'h800800);
    chk(32'({per_in.analog_connect, per_in.comparator_connect}), 32'h203);
    cfg(9'h180, 12'h000, 12'h000, 8'h02, 12'h000, 1'b0);
    chk(32'({pin_oe, per_in.analog_connect, per_in.comparator_connect}), 32'h080b);
    for (int i = 0; i < 7; i++) begin
      cfg(ck[i], 12'h000, 12'h000, 8'h00, 12'h000, 1'b0);
      chk(32'(pin_oe), 32'(oe[i]));
    end
    for (int r = 0; r < 2; r++) begin
      cfg({7'h0, r[0], 1'b0}, 12'h000, 12'h000, 8'h00, r[0] ? 12'h810 : 12'h401, 1'b0);
      chk(32'({per_in.usart_rx_pin, per_in.capture_in, per_in.count_in}), r[0] ? 32'h7 : 32'h3);
    end
    cfg(9'h000, 12'h000, 12'hfff, 8'h00, 12'h7a3, 1'b0);
    chk(32'({per_in.usart_clock_pin, per_in.ext_irq_line, per_in.pin_change_irq}), 32'h37a3);
    cfg(9'h000, 12'h000, 12'h000, 8'h00, 12'h005, 1'b1);
    chk(32'({per_in.prog_clock_pin, per_in.prog_reset_pin}), 32'h3);
    @(posedge clk);
    prog_mode <= 1'b0;
    bus(1'b1, PPFM_OFF_GDIR, 32'hfff);
    settle();
    chk(32'(pin_oe), 32'hfff);
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    chk(32'(pin_oe), 32'h0);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(PPFM_OFF_GDIR, 32'h0);
    finish_test();
  end
endmodule : ppfm_mux_tb
`default_nettype wire
